/* File: nce_defines.svh */
// constants for the nibble execution core: register offsets, field spots, resets
// assumes inclusion by the core module and the test bench only
`ifndef NCE_DEFINES_SVH
`define NCE_DEFINES_SVH

// -------------------------------------------------------------------
// register offsets (word index on the plain register port)
// -------------------------------------------------------------------
`define NCE_REG_CTRL 4'h0
`define NCE_REG_STATUS 4'h1
`define NCE_REG_MASK 4'h2
`define NCE_REG_PC 4'h3
`define NCE_REG_PTR 4'h4
`define NCE_REG_DATA 4'h5
`define NCE_REG_STATE 4'h6

// -------------------------------------------------------------------
// field positions
// -------------------------------------------------------------------
`define NCE_CTRL_MASK_BIT 0
`define NCE_CTRL_POL_BIT 1
`define NCE_EV_SKIP 0
`define NCE_EV_OVER 1
`define NCE_EV_UNDER 2
`define NCE_EV_EXT0 3
`define NCE_EV_W 4

// -------------------------------------------------------------------
// reset values and steps
// -------------------------------------------------------------------
`define NCE_PC_RST 14'h0000
`define NCE_SP_RST 3'h7
`define NCE_LVL_RST 4'h0
`define NCE_LVL_FULL 4'h8
`define NCE_CTRL_RST 2'h0
`define NCE_PC_STEP1 14'h0001
`define NCE_PC_STEP2 14'h0002
`define NCE_SP_STEP 3'h1
`define NCE_LVL_STEP 4'h1

`endif

/* File: nce_pkg.sv */
// types for the nibble execution core: decoded operations and states
// assumes the instruction decoder upstream delivers one of these codes
package nce_pkg;

  // decoded operations presented on the instruction port
  typedef enum logic [4:0] {
    NCE_NOP = 5'h00,
    NCE_BRANCH = 5'h01,
    NCE_LONG_JUMP = 5'h02,
    NCE_CALL_LONG = 5'h03,
    NCE_TABLE_FETCH_CALL = 5'h04,
    NCE_SUB_RETURN = 5'h05,
    NCE_RETURN_SKIP = 5'h06,
    NCE_SET_BIT = 5'h07,
    NCE_CLR_BIT = 5'h08,
    NCE_SKIP_IF_BIT_ZERO = 5'h09,
    NCE_SWAP_ACC_MEM = 5'h0A,
    NCE_LOAD_PAIR_FROM_NIBBLES = 5'h0B,
    NCE_UNLOAD_PAIR = 5'h0C,
    NCE_SKIP_ON_EXT0_REQ = 5'h0D,
    NCE_SKIP_ON_PIN_LEVEL = 5'h0E,
    NCE_LOAD_PTR = 5'h0F,
    NCE_LOAD_ACC = 5'h10,
    NCE_LOAD_UPPER = 5'h11,
    NCE_LOAD_DR = 5'h12
  } nce_op_t;

  // core sequencing states
  typedef enum logic [1:0] {
    NCE_ST_RUN = 2'b00,
    NCE_ST_SECOND = 2'b01,
    NCE_ST_FETCH = 2'b10
  } nce_state_t;

endpackage

/* File: nce_exec_core.sv */
// execution core of a 4-bit controller: program counter, call stack,
// ram pointer, pair register and the skip mechanism
// assumes an upstream decoder presents decoded ops, and ram/rom answer
// combinationally at the addresses this core drives
//
// How it works
// RULE1: a taken skip suppresses the next instruction but still consumes its slot
// RULE2: skipping adds one to the pc, two only past a suppressed two-word op; suppressed two-word ops keep both cycles
// RULE3: suppressed table fetch, return or return-skip take only one cycle
// RULE4: eight stack entries of 14 bits, selected by the stack pointer
// RULE5: pc is a 7-bit page field above a 7-bit in-page offset
// RULE6: ram pointer is bank, file and word selectors concatenated, 10 bits
// RULE7: pair load puts upper nibble in bits 7-4, working nibble in 3-0
// RULE8: bit set, clear, test address one ram bit; test skips on zero
// RULE9: ext0 skip with mask 0 skips on flag and clears it; mask 1 is nop
// RULE10: pin skip tests the pin, high when polarity is 1, low when 0
// RULE11: long jump loads page field and in-page offset from operands
// RULE12: swap exchanges acc with ram nibble and xors file selector with immediate
// RULE13: call and table fetch increment pointer, then store the return address there
// RULE14: return reloads pc from stack then decrements; return-skip also skips
`timescale 1ns/1ps
`include "nce_defines.svh"

module nce_exec_core import nce_pkg::*; #(
  parameter int PAGE_W = 7,
  parameter int SP_W = 3,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ins_valid,
  input wire logic [4:0] i_op,
  input wire logic [6:0] i_opd,
  input wire logic [6:0] i_page,
  input wire logic [9:0] i_rom_data,
  input wire logic [3:0] i_ram_rdata,
  input wire logic i_ext0_req,
  input wire logic i_ext0_pin,
  input wire logic [3:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  output logic o_ins_ready,
  output logic [13:0] o_pc,
  output logic [9:0] o_ram_addr,
  output logic [9:0] o_ram_waddr,
  output logic [3:0] o_ram_wdata,
  output logic o_ram_we,
  output logic [7:0] o_pair,
  output logic [15:0] o_reg_rdata,
  output logic o_irq
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  localparam int PC_W = 2 * PAGE_W;
  nce_state_t state_ff, nxt_state;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic [PC_W-1:0] call_stack [DEPTH];
  logic [SP_W-1:0] sp_ff, nxt_sp;
  logic [3:0] lvl_ff, nxt_lvl;
  logic [1:0] bank_ff, nxt_bank;
  logic [3:0] file_ff, nxt_file;
  logic [3:0] word_ff, nxt_word;
  logic [3:0] acc_ff, nxt_acc;
  logic [3:0] upper_ff, nxt_upper;
  logic [2:0] dr_ff, nxt_dr;
  logic [7:0] pair_ff, nxt_pair;
  logic skip_ff, nxt_skip;
  logic ready_ff;
  logic ext0_flag_ff;
  logic [1:0] ctrl_ff;
  logic [`NCE_EV_W-1:0] status_ff, mask_ff;
  logic [15:0] rdata_ff;
  logic [3:0] wdata_ff, nxt_wdata;
  logic [9:0] waddr_ff;
  logic we_ff, nxt_we;
  logic push, pop;
  logic [PC_W-1:0] push_val;

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  // instruction taken when offered while ready; suppression follows skip
  wire take = i_ins_valid & ready_ff & (state_ff == NCE_ST_RUN);
  wire nce_op_t op = nce_op_t'(i_op);
  wire sup = take & skip_ff;
  wire exec = take & ~skip_ff;
  wire two_word = (op == NCE_LONG_JUMP) | (op == NCE_CALL_LONG);
  wire short_on_skip = (op == NCE_TABLE_FETCH_CALL) | (op == NCE_SUB_RETURN) |
                       (op == NCE_RETURN_SKIP);
  wire is_ret = (op == NCE_SUB_RETURN) | (op == NCE_RETURN_SKIP);
  wire [1:0] bit_idx = i_opd[1:0];
  wire [PC_W-1:0] pc_inc1 = pc_ff + `NCE_PC_STEP1;
  wire [PC_W-1:0] pc_inc2 = pc_ff + `NCE_PC_STEP2;
  wire [SP_W-1:0] sp_up = sp_ff + `NCE_SP_STEP;
  wire [SP_W-1:0] sp_dn = sp_ff - `NCE_SP_STEP;
  wire [PC_W-1:0] stack_top = call_stack[sp_ff];
  wire mask_ext0 = ctrl_ff[`NCE_CTRL_MASK_BIT];
  wire pin_pol = ctrl_ff[`NCE_CTRL_POL_BIT];
  // RULE6: pointer concatenation
  wire [9:0] ram_ptr = {bank_ff, file_ff, word_ff};
  wire pin_hit = (i_ext0_pin == pin_pol);
  wire ext0_take = exec & (op == NCE_SKIP_ON_EXT0_REQ) & ~mask_ext0 & ext0_flag_ff;

  // one select line per nibble bit
  logic [3:0] bit_sel;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bit
      assign bit_sel[gi] = (bit_idx == gi[1:0]);
    end
  endgenerate
  wire ram_bit = |(i_ram_rdata & bit_sel);

  // register port decode
  wire wr_ctrl = i_reg_we & (i_reg_addr == `NCE_REG_CTRL);
  wire wr_status = i_reg_we & (i_reg_addr == `NCE_REG_STATUS);
  wire wr_mask = i_reg_we & (i_reg_addr == `NCE_REG_MASK);

  // -------------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------------
  // one slot per taken word; the pc steps two past a suppressed two-word op
  always_comb begin
    nxt_state = NCE_ST_RUN;
    nxt_pc = pc_ff;
    nxt_sp = sp_ff;
    nxt_lvl = lvl_ff;
    nxt_bank = bank_ff;
    nxt_file = file_ff;
    nxt_word = word_ff;
    nxt_acc = acc_ff;
    nxt_upper = upper_ff;
    nxt_dr = dr_ff;
    nxt_pair = pair_ff;
    nxt_skip = skip_ff;
    nxt_wdata = wdata_ff;
    nxt_we = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_val = pc_inc1;
    if (state_ff == NCE_ST_FETCH) begin
      // second cycle of table fetch: rom word read at the table address
      nxt_upper = i_rom_data[7:4];
      nxt_acc = i_rom_data[3:0];
      nxt_pc = stack_top;
      nxt_sp = sp_dn;
      pop = 1'b1;
    end else if (sup) begin
      // RULE1: suppressed slot consumed
      nxt_skip = 1'b0;
      // RULE2: plain step, two-word ops still stall
      nxt_pc = two_word ? pc_inc2 : pc_inc1;
      nxt_state = two_word ? NCE_ST_SECOND : NCE_ST_RUN;
      // RULE3: short suppressed forms
      if (short_on_skip) begin
        nxt_state = NCE_ST_RUN;
      end
    end else if (exec) begin
      nxt_pc = pc_inc1;
      unique case (op)
        NCE_BRANCH: begin
          nxt_pc = {pc_ff[PC_W-1:PAGE_W], i_opd};
        end
        NCE_LONG_JUMP: begin
          // RULE11: page and offset loaded
          // RULE5: page field over offset
          nxt_pc = {i_page, i_opd};
          nxt_state = NCE_ST_SECOND;
        end
        NCE_CALL_LONG: begin
          // RULE13: push return address
          push = 1'b1;
          push_val = pc_inc2;
          nxt_sp = sp_up;
          nxt_pc = {i_page, i_opd};
          nxt_state = NCE_ST_SECOND;
        end
        NCE_TABLE_FETCH_CALL: begin
          // RULE13: push before table read
          push = 1'b1;
          nxt_sp = sp_up;
          nxt_pc = {i_page, dr_ff, acc_ff};
          nxt_state = NCE_ST_FETCH;
        end
        NCE_SUB_RETURN, NCE_RETURN_SKIP: begin
          // RULE14: reload then decrement
          pop = 1'b1;
          nxt_pc = stack_top;
          nxt_sp = sp_dn;
          nxt_skip = (op == NCE_RETURN_SKIP);
          nxt_state = NCE_ST_SECOND;
        end
        NCE_SET_BIT, NCE_CLR_BIT: begin
          // RULE8: one bit of the pointed nibble
          nxt_we = 1'b1;
          nxt_wdata = (op == NCE_SET_BIT) ? (i_ram_rdata | bit_sel) : (i_ram_rdata & ~bit_sel);
        end
        NCE_SKIP_IF_BIT_ZERO: begin
          // RULE8: skip on zero bit
          nxt_skip = ~ram_bit;
        end
        NCE_SWAP_ACC_MEM: begin
          // RULE12: exchange and file xor
          nxt_we = 1'b1;
          nxt_wdata = acc_ff;
          nxt_acc = i_ram_rdata;
          nxt_file = file_ff ^ i_opd[3:0];
        end
        NCE_LOAD_PAIR_FROM_NIBBLES: begin
          // RULE7: upper nibble high, acc low
          nxt_pair = {upper_ff, acc_ff};
        end
        NCE_UNLOAD_PAIR: begin
          // RULE7: copy back same lanes
          nxt_upper = pair_ff[7:4];
          nxt_acc = pair_ff[3:0];
        end
        NCE_SKIP_ON_EXT0_REQ: begin
          // RULE9: masked form does nothing
          nxt_skip = ext0_take;
        end
        NCE_SKIP_ON_PIN_LEVEL: begin
          // RULE10: level against polarity
          nxt_skip = pin_hit;
        end
        NCE_LOAD_PTR: begin
          nxt_bank = i_page[5:4];
          nxt_file = i_page[3:0];
          nxt_word = i_opd[3:0];
        end
        NCE_LOAD_ACC: nxt_acc = i_opd[3:0];
        NCE_LOAD_UPPER: nxt_upper = i_opd[3:0];
        NCE_LOAD_DR: nxt_dr = i_opd[2:0];
        default: nxt_pc = pc_inc1;
      endcase
    end
    if (push && lvl_ff != `NCE_LVL_FULL) begin
      nxt_lvl = lvl_ff + `NCE_LVL_STEP;
    end else if (pop && lvl_ff != `NCE_LVL_RST) begin
      nxt_lvl = lvl_ff - `NCE_LVL_STEP;
    end
  end

  // events for the sticky status register
  wire [`NCE_EV_W-1:0] events = {i_ext0_req, pop & (lvl_ff == `NCE_LVL_RST),
                                 push & (lvl_ff == `NCE_LVL_FULL), nxt_skip & ~skip_ff};

  // next status and mask; irq is built from both so a masked event never leaks
  wire [`NCE_EV_W-1:0] st_clr = wr_status ? i_reg_wdata[`NCE_EV_W-1:0] : '0;
  wire [`NCE_EV_W-1:0] nxt_status = events | (status_ff & ~st_clr);
  wire [`NCE_EV_W-1:0] nxt_mask = wr_mask ? i_reg_wdata[`NCE_EV_W-1:0] : mask_ff;

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  // core datapath flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= NCE_ST_RUN;
      pc_ff <= `NCE_PC_RST;
      sp_ff <= `NCE_SP_RST;
      lvl_ff <= `NCE_LVL_RST;
      {bank_ff, file_ff, word_ff} <= '0;
      {acc_ff, upper_ff, dr_ff, pair_ff} <= '0;
      skip_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
      lvl_ff <= nxt_lvl;
      {bank_ff, file_ff, word_ff} <= {nxt_bank, nxt_file, nxt_word};
      {acc_ff, upper_ff, dr_ff, pair_ff} <= {nxt_acc, nxt_upper, nxt_dr, nxt_pair};
      skip_ff <= nxt_skip;
      ready_ff <= (nxt_state == NCE_ST_RUN);
    end
  end

  // RULE4: stack entry written at the bumped pointer
  always_ff @(posedge i_clk) begin
    if (push) begin
      call_stack[sp_up] <= push_val;
    end
  end

  // ram write port; address latched so a pointer change cannot skew it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      we_ff <= 1'b0;
      wdata_ff <= '0;
      waddr_ff <= '0;
    end else begin
      we_ff <= nxt_we;
      wdata_ff <= nxt_wdata;
      waddr_ff <= nxt_we ? ram_ptr : waddr_ff;
    end
  end

  // RULE9: request flag; a new request beats the clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext0_flag_ff <= 1'b0;
    end else begin
      ext0_flag_ff <= i_ext0_req | (ext0_flag_ff & ~ext0_take);
    end
  end

  // software control, mask and write-one-to-clear status; set wins
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_ff <= `NCE_CTRL_RST;
      mask_ff <= '0;
      status_ff <= '0;
      o_irq <= 1'b0;
    end else begin
      ctrl_ff <= wr_ctrl ? i_reg_wdata[1:0] : ctrl_ff;
      mask_ff <= nxt_mask;
      status_ff <= nxt_status;
      o_irq <= |(nxt_status & nxt_mask);
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  wire [15:0] rd_mux =
    (i_reg_addr == `NCE_REG_CTRL) ? {14'h0000, ctrl_ff} :
    (i_reg_addr == `NCE_REG_STATUS) ? {12'h000, status_ff} :
    (i_reg_addr == `NCE_REG_MASK) ? {12'h000, mask_ff} :
    (i_reg_addr == `NCE_REG_PC) ? {2'h0, pc_ff} :
    (i_reg_addr == `NCE_REG_PTR) ? {6'h00, ram_ptr} :
    (i_reg_addr == `NCE_REG_DATA) ? {upper_ff, acc_ff, pair_ff} :
    (i_reg_addr == `NCE_REG_STATE) ? {7'h00, dr_ff, ext0_flag_ff, skip_ff, lvl_ff} :
    16'h0000;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= i_reg_re ? rd_mux : 16'h0000;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign o_ins_ready = ready_ff;
  assign o_pc = pc_ff;
  assign o_ram_addr = ram_ptr;
  assign o_ram_waddr = waddr_ff;
  assign o_ram_wdata = wdata_ff;
  assign o_ram_we = we_ff;
  assign o_pair = pair_ff;
  assign o_reg_rdata = rdata_ff;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  property p_sup_no_write;
    @(posedge i_clk) disable iff (!i_nrst)
    sup && (op == NCE_SET_BIT || op == NCE_SWAP_ACC_MEM) |=> !o_ram_we;
  endproperty
  a_sup_no_write: assert property (p_sup_no_write) else $error("suppressed op wrote ram"); // RULE1

  property p_sup_step;
    @(posedge i_clk) disable iff (!i_nrst)
    sup && !two_word |=> o_pc == $past(o_pc) + `NCE_PC_STEP1;
  endproperty
  a_sup_step: assert property (p_sup_step) else $error("skip moved pc wrongly"); // RULE2

  property p_sup_short;
    @(posedge i_clk) disable iff (!i_nrst)
    sup && short_on_skip |=> o_ins_ready;
  endproperty
  a_sup_short: assert property (p_sup_short) else $error("suppressed return stalled"); // RULE3

  property p_call_push;
    @(posedge i_clk) disable iff (!i_nrst)
    exec && op == NCE_CALL_LONG |=> call_stack[sp_ff] == $past(o_pc) + `NCE_PC_STEP2
      ##1 o_ins_ready;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong"); // RULE13

  property p_jump;
    @(posedge i_clk) disable iff (!i_nrst)
    exec && op == NCE_LONG_JUMP |=> o_pc == {$past(i_page), $past(i_opd)} && !o_ins_ready;
  endproperty
  a_jump: assert property (p_jump) else $error("long jump target wrong"); // RULE11

  property p_pair;
    @(posedge i_clk) disable iff (!i_nrst)
    exec && op == NCE_LOAD_PAIR_FROM_NIBBLES |=> o_pair == {$past(upper_ff), $past(acc_ff)};
  endproperty
  a_pair: assert property (p_pair) else $error("pair lanes wrong"); // RULE7

  property p_ext0;
    @(posedge i_clk) disable iff (!i_nrst)
    exec && op == NCE_SKIP_ON_EXT0_REQ && mask_ext0 |=> !skip_ff;
  endproperty
  a_ext0: assert property (p_ext0) else $error("masked ext0 skip acted"); // RULE9

  property p_pin;
    @(posedge i_clk) disable iff (!i_nrst)
    exec && op == NCE_SKIP_ON_PIN_LEVEL |=> skip_ff == ($past(i_ext0_pin) == $past(pin_pol));
  endproperty
  a_pin: assert property (p_pin) else $error("pin skip wrong"); // RULE10

  property p_bitz;
    @(posedge i_clk) disable iff (!i_nrst)
    exec && op == NCE_SKIP_IF_BIT_ZERO |=> skip_ff == !$past(ram_bit);
  endproperty
  a_bitz: assert property (p_bitz) else $error("bit test skip wrong"); // RULE8

  property p_swap;
    @(posedge i_clk) disable iff (!i_nrst)
    exec && op == NCE_SWAP_ACC_MEM |=> o_ram_we && o_ram_wdata == $past(acc_ff)
      && file_ff == ($past(file_ff) ^ $past(i_opd[3:0]));
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong"); // RULE12

  property p_ret;
    @(posedge i_clk) disable iff (!i_nrst)
    exec && is_ret |=> o_pc == $past(stack_top) && sp_ff == $past(sp_ff) - `NCE_SP_STEP;
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong"); // RULE14

  property p_ptr;
    @(posedge i_clk) disable iff (!i_nrst)
    exec && op == NCE_LOAD_PTR |=> o_ram_addr == {$past(i_page[5:0]), $past(i_opd[3:0])};
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer wrong"); // RULE6

  c_skip_then_sup: cover property (@(posedge i_clk) disable iff (!i_nrst) exec ##[1:3] sup);
  c_table: cover property (@(posedge i_clk) disable iff (!i_nrst)
    exec && op == NCE_TABLE_FETCH_CALL);
  c_irq: cover property (@(posedge i_clk) disable iff (!i_nrst) o_irq);

endmodule

/* File: nce_mem_model.sv */
// program rom and data ram standing beside the execution core
// assumes the core reads rom and ram combinationally at the addresses it drives
`timescale 1ns/1ps

module nce_mem_model (
  input wire logic i_clk,
  input wire logic [13:0] i_pc,
  input wire logic [9:0] i_ram_addr,
  input wire logic [9:0] i_ram_waddr,
  input wire logic [3:0] i_ram_wdata,
  input wire logic i_ram_we,
  output logic [9:0] o_rom_data,
  output logic [3:0] o_ram_rdata
);
  // -------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------
  logic [3:0] ram_ff [1024];

  // rom is a scramble of the address so neighbouring words differ
  assign o_rom_data = i_pc[9:0] ^ 10'h35A;
  assign o_ram_rdata = ram_ff[i_ram_addr];

  // seeded contents; real ram has no reset either
  initial begin
    for (int i = 0; i < 1024; i++) begin
      ram_ff[i] = 4'(i) ^ 4'h9;
    end
  end

  // write pulse lands at the edge that samples it
  always @(posedge i_clk) begin
    if (i_ram_we) begin
      ram_ff[i_ram_waddr] <= i_ram_wdata;
    end
  end
endmodule

/* File: nibble_cpu_exec_core_test.sv */
// self-checking bench for the nibble execution core
// assumes a 10 MHz clock and the rom/ram model in nce_mem_model.sv
`timescale 1ns/1ps
`include "nce_defines.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("Error at %0t: mismatch got %h expected %h", $time, (a), (b)); end end

module nibble_cpu_exec_core_test import nce_pkg::*; ;
  // -------------------------------------------------------------------
  // signals
  // -------------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic ins_valid = 1'b0;
  logic [4:0] op = 5'h00;
  logic [6:0] opd = 7'h00;
  logic [6:0] page = 7'h00;
  logic ext_req = 1'b0;
  logic ext_pin = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic ready, ram_we, irq;
  logic [13:0] pc;
  logic [9:0] ram_addr, ram_waddr, rom_data;
  logic [3:0] ram_wdata, ram_rdata;
  logic [7:0] pair;
  logic [15:0] rdata, rd;
  logic [13:0] epc = 14'h0000;
  int err_count = 0;
  int check_count = 0;

  nce_exec_core dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ins_valid(ins_valid), .i_op(op),
    .i_opd(opd), .i_page(page), .i_rom_data(rom_data), .i_ram_rdata(ram_rdata),
    .i_ext0_req(ext_req), .i_ext0_pin(ext_pin), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_we(reg_we), .i_reg_re(reg_re), .o_ins_ready(ready),
    .o_pc(pc), .o_ram_addr(ram_addr), .o_ram_waddr(ram_waddr), .o_ram_wdata(ram_wdata),
    .o_ram_we(ram_we), .o_pair(pair), .o_reg_rdata(rdata), .o_irq(irq));
  nce_mem_model mem (.i_clk(i_clk), .i_pc(pc), .i_ram_addr(ram_addr),
    .i_ram_waddr(ram_waddr), .i_ram_wdata(ram_wdata), .i_ram_we(ram_we),
    .o_rom_data(rom_data), .o_ram_rdata(ram_rdata));

  // 100 ns period
  always #50 i_clk = ~i_clk;

  // -------------------------------------------------------------------
  // bus and instruction tasks
  // -------------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    {reg_addr, reg_wdata, reg_we} <= {a, d, 1'b1};
    @(posedge i_clk);
    reg_we <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a);
    @(posedge i_clk);
    {reg_addr, reg_re} <= {a, 1'b1};
    @(posedge i_clk);
    reg_re <= 1'b0;
    @(negedge i_clk);
    rd = rdata;
  endtask

  // offer one op, hold it until taken, return in the cycle after the take
  task automatic issue(input nce_op_t o, input logic [6:0] d, input logic [6:0] p);
    int n;
    n = 0;
    @(posedge i_clk);
    {ins_valid, op, opd, page} <= {1'b1, o, d, p};
    @(negedge i_clk);
    while (ready !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
    ins_valid <= 1'b0;
    @(negedge i_clk);
  endtask

  task automatic op1(input nce_op_t o, input logic [6:0] d, input logic [6:0] p);
    issue(o, d, p);
    epc = epc + 14'h1;
    `CHK({ready, pc}, {1'b1, epc})
  endtask

  // acc ends 6 if the probed op skipped the following load, else 1
  // eirq: irq level expected right after the probed op; a skip event alone is masked
  task automatic skip_probe(input nce_op_t o, input logic [6:0] d, input logic eirq);
    op1(NCE_LOAD_ACC, 7'h06, 7'h00);
    op1(o, d, 7'h00);
    `CHK(irq, eirq)
    op1(NCE_LOAD_ACC, 7'h01, 7'h00);
    reg_rd(`NCE_REG_DATA);
  endtask

  task automatic pulse();
    @(posedge i_clk);
    ext_req <= 1'b1;
    @(posedge i_clk);
    ext_req <= 1'b0;
    repeat (2) @(negedge i_clk);
  endtask

  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    `CHK({ready, pc, irq}, {1'b1, 14'h0000, 1'b0})
    reg_wr(`NCE_REG_PC, 16'hFFFF);
    reg_wr(4'hF, 16'hFFFF);
    for (int a = 0; a < 16; a++) begin
      reg_rd(4'(a));
      `CHK(rd, 16'h0000)
    end
  endtask

  task automatic t_ptr_pair();
    op1(NCE_LOAD_PTR, 7'h05, 7'h2A);
    `CHK(ram_addr, 10'h2A5)
    op1(NCE_LOAD_ACC, 7'h03, 7'h00);
    op1(NCE_LOAD_UPPER, 7'h0C, 7'h00);
    op1(NCE_LOAD_PAIR_FROM_NIBBLES, 7'h00, 7'h00);
    `CHK(pair, 8'hC3)
    op1(NCE_LOAD_ACC, 7'h00, 7'h00);
    op1(NCE_LOAD_UPPER, 7'h00, 7'h00);
    op1(NCE_UNLOAD_PAIR, 7'h00, 7'h00);
    reg_rd(`NCE_REG_DATA);
    `CHK(rd, 16'hC3C3)
  endtask

  // swap, then bit ops on the nibble at the pointer the swap left behind
  task automatic t_swap_bits();
    op1(NCE_SWAP_ACC_MEM, 7'h06, 7'h00);
    `CHK({ram_we, ram_waddr, ram_wdata, ram_addr}, {1'b1, 10'h2A5, 4'h3, 10'h2C5})
    reg_rd(`NCE_REG_DATA);
    `CHK(rd[11:8], 4'hC)
    op1(NCE_SET_BIT, 7'h00, 7'h00);
    `CHK({ram_we, ram_waddr, ram_wdata}, {1'b1, 10'h2C5, 4'hD})
    op1(NCE_CLR_BIT, 7'h03, 7'h00);
    `CHK({ram_we, ram_wdata}, {1'b1, 4'h5})
    skip_probe(NCE_SKIP_IF_BIT_ZERO, 7'h01, 1'b0);
    `CHK(rd[11:8], 4'h6)
    skip_probe(NCE_SKIP_IF_BIT_ZERO, 7'h02, 1'b0);
    `CHK(rd[11:8], 4'h1)
  endtask

  // eight nested calls, unwound in reverse, then one pop too many
  task automatic t_stack();
    issue(NCE_LONG_JUMP, 7'h11, 7'h05);
    `CHK({ready, pc}, {1'b0, 14'h0291})
    epc = 14'h0291;
    op1(NCE_NOP, 7'h00, 7'h00);
    reg_wr(`NCE_REG_MASK, 16'h0004);
    for (int i = 0; i < 8; i++) begin
      issue(NCE_CALL_LONG, 7'(i * 8), 7'h01);
      `CHK(pc, 14'h0080 + 14'(i * 8))
    end
    reg_rd(`NCE_REG_STATE);
    `CHK(rd[3:0], 4'h8)
    reg_rd(`NCE_REG_STATUS);
    `CHK(rd[1], 1'b0)
    for (int i = 7; i >= 0; i--) begin
      issue(NCE_SUB_RETURN, 7'h00, 7'h00);
      `CHK(pc, (i == 0) ? epc + 14'h2 : 14'h0082 + 14'((i - 1) * 8))
    end
    `CHK(irq, 1'b0)
    issue(NCE_SUB_RETURN, 7'h00, 7'h00);
    @(negedge i_clk);
    `CHK(irq, 1'b1)
    reg_wr(`NCE_REG_STATUS, 16'h0004);
    repeat (2) @(negedge i_clk);
    `CHK(irq, 1'b0)
    issue(NCE_LONG_JUMP, 7'h00, 7'h04);
    epc = 14'h0200;
  endtask

  task automatic t_skip_timing();
    issue(NCE_CALL_LONG, 7'h00, 7'h03);
    issue(NCE_RETURN_SKIP, 7'h00, 7'h00);
    `CHK(pc, epc + 14'h2)
    epc = epc + 14'h2;
    op1(NCE_SUB_RETURN, 7'h00, 7'h00);
    reg_rd(`NCE_REG_STATE);
    `CHK(rd[4:0], 5'h00)
    reg_rd(`NCE_REG_STATUS);
    `CHK(rd[2], 1'b0)
    op1(NCE_SKIP_IF_BIT_ZERO, 7'h01, 7'h00);
    op1(NCE_TABLE_FETCH_CALL, 7'h00, 7'h02);
    op1(NCE_SKIP_IF_BIT_ZERO, 7'h01, 7'h00);
    issue(NCE_LONG_JUMP, 7'h11, 7'h05);
    `CHK(ready, 1'b0)
    epc = epc + 14'h2;
    op1(NCE_NOP, 7'h00, 7'h00);
  endtask

  task automatic t_table();
    op1(NCE_LOAD_DR, 7'h03, 7'h00);
    op1(NCE_LOAD_ACC, 7'h05, 7'h00);
    issue(NCE_TABLE_FETCH_CALL, 7'h00, 7'h02);
    `CHK({ready, pc}, {1'b0, 14'h0135})
    @(negedge i_clk);
    epc = epc + 14'h1;
    `CHK({ready, pc}, {1'b1, epc})
    reg_rd(`NCE_REG_DATA);
    `CHK(rd[15:8], 8'h6F)
  endtask

  task automatic t_ext0();
    reg_wr(`NCE_REG_CTRL, 16'h0000);
    reg_wr(`NCE_REG_MASK, 16'h0008);
    pulse();
    `CHK(irq, 1'b1)
    skip_probe(NCE_SKIP_ON_EXT0_REQ, 7'h00, 1'b1);
    `CHK(rd[11:8], 4'h6)
    reg_rd(`NCE_REG_STATE);
    `CHK(rd[5], 1'b0)
    reg_wr(`NCE_REG_STATUS, 16'h000F);
    reg_wr(`NCE_REG_CTRL, 16'h0001);
    pulse();
    skip_probe(NCE_SKIP_ON_EXT0_REQ, 7'h00, 1'b1);
    `CHK(rd[11:8], 4'h1)
    reg_rd(`NCE_REG_STATE);
    `CHK(rd[5], 1'b1)
    reg_wr(`NCE_REG_STATUS, 16'h000F);
    repeat (2) @(negedge i_clk);
    `CHK(irq, 1'b0)
  endtask

  // every polarity against every pin level
  task automatic t_pin();
    for (int k = 0; k < 4; k++) begin
      reg_wr(`NCE_REG_CTRL, {14'h0000, k[1], 1'b1});
      ext_pin <= k[0];
      skip_probe(NCE_SKIP_ON_PIN_LEVEL, 7'h00, 1'b0);
      `CHK(rd[11:8], (k[1] == k[0]) ? 4'h6 : 4'h1)
    end
  endtask

  // -------------------------------------------------------------------
  // sequence and watchdog
  // -------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    t_reset();
    t_ptr_pair();
    t_swap_bits();
    t_stack();
    t_skip_timing();
    t_table();
    t_ext0();
    t_pin();
    conclude();
  end

  // the whole run needs well under 2000 cycles
  initial begin
    #2000000;
    err_count++;
    conclude();
  end
endmodule
